// ==== mrsa_alu.sv ====
// Rotate, subtract, skip, swap, table-read and XOR execution datapath
`timescale 1ns/100ps

module mrsa_alu #(
	parameter int PC_W   = 11,                 // Program address width
	parameter int WORD_W = 14                  // Program word width
) (
	input  wire logic              i_core_clk,    // Machine-cycle clock
	input  wire logic              i_rst_b,       // Async reset, low
	input  wire logic              i_valid,       // Request strobe
	input  wire mrsa_pkg::mrsa_req_t i_req,       // Operation and operands
	input  wire logic [PC_W-1:0]   i_pc,          // Current program counter
	input  wire logic [7:0]        i_table_pointer, // Table offset
	input  wire logic [WORD_W-1:0] i_prog_data,   // Program word read back
	output logic                   o_ready,       // Can take a request
	output logic [PC_W-1:0]        o_prog_addr,   // Program read address
	output logic                   o_prog_rd,     // Program read strobe
	output logic                   o_mem_we,      // Data memory write
	output logic [7:0]             o_mem_wdata,   // Data memory byte
	output logic                   o_skip,        // Skip next instruction
	output logic [7:0]             o_acc,         // Accumulator
	output mrsa_pkg::mrsa_flags_t  o_flags,       // Status flags
	output logic [7:0]             o_table_high_latch // Table high bits
);

	// Refuse widths the page and latch slicing cannot serve
	if (PC_W < 9 || WORD_W < 9 || WORD_W > 16) begin : g_width_chk
		$error("mrsa_alu: unsupported widths");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MRSA_ST_IDLE  = 2'b00,                 // Accept requests
		MRSA_ST_DUMMY = 2'b01,                 // Second cycle of skip
		MRSA_ST_TABLE = 2'b10                  // Waiting for program word
	} mrsa_st_t;

	mrsa_st_t              st_r, st_nxt;          // Sequencer state
	logic [7:0]            acc_r, acc_nxt;        // Accumulator
	mrsa_pkg::mrsa_flags_t flg_r, flg_nxt;        // Flags
	logic [7:0]            tbh_r, tbh_nxt;        // Table high latch
	logic                  we_r, we_nxt;          // Memory write
	logic [7:0]            wd_r, wd_nxt;          // Memory write data
	logic                  skip_r, skip_nxt;      // Skip pulse
	logic                  rd_r, rd_nxt;          // Program read
	logic [PC_W-1:0]       pa_r, pa_nxt;          // Program address

	// Subtraction helpers
	logic [7:0] sub_b;                            // Subtrahend
	logic       sub_bin;                          // Borrow in
	logic [8:0] sub_full;                         // 9-bit difference
	logic [4:0] sub_low;                          // Low nibble difference
	logic [7:0] sub_res;                          // Difference byte
	mrsa_pkg::mrsa_flags_t sub_flg;               // Subtract flags
	logic [7:0] dec_v, inc_v, xin, xres;          // Misc results

	// ------------------------------------------------------------
	// Subtractor: a - b - borrow, borrow is inverted carry when chained
	// ------------------------------------------------------------
	always_comb begin
		sub_b    = (i_req.op == mrsa_pkg::MRSA_OP_SUBI) ? i_req.imm : i_req.mem;
		sub_bin  = (i_req.op == mrsa_pkg::MRSA_OP_SUBB ||
		            i_req.op == mrsa_pkg::MRSA_OP_SUBBM) ? ~flg_r.carry_flag
		                                                 : 1'b0;
		sub_full = {1'b0, acc_r} - {1'b0, sub_b} - {8'h00, sub_bin};
		sub_low  = {1'b0, acc_r[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, sub_bin};
		sub_res  = sub_full[7:0];
		sub_flg.carry_flag      = ~sub_full[8];
		sub_flg.half_carry_flag = ~sub_low[4];
		sub_flg.zero_flag       = (sub_res == 8'h00);
		sub_flg.signed_wrap_flag = (acc_r[7] != sub_b[7]) &&
		                           (sub_res[7] != acc_r[7]);
		dec_v = i_req.mem - 8'h01;
		inc_v = i_req.mem + 8'h01;
		xin   = (i_req.op == mrsa_pkg::MRSA_OP_XORI) ? i_req.imm : i_req.mem;
		xres  = acc_r ^ xin;
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		st_nxt   = st_r;
		acc_nxt  = acc_r;
		flg_nxt  = flg_r;
		tbh_nxt  = tbh_r;
		we_nxt   = 1'b0;
		wd_nxt   = wd_r;
		skip_nxt = 1'b0;
		rd_nxt   = 1'b0;
		pa_nxt   = pa_r;
		case (st_r)
			MRSA_ST_IDLE: begin
				if (i_valid) begin
					case (i_req.op)
						mrsa_pkg::MRSA_OP_RLA:
							acc_nxt = {i_req.mem[6:0], i_req.mem[7]};
						mrsa_pkg::MRSA_OP_RR: begin
							we_nxt = 1'b1;
							wd_nxt = {i_req.mem[0], i_req.mem[7:1]};
						end
						mrsa_pkg::MRSA_OP_RRA:
							acc_nxt = {i_req.mem[0], i_req.mem[7:1]};
						mrsa_pkg::MRSA_OP_RLF: begin
							we_nxt = 1'b1;
							wd_nxt = {i_req.mem[6:0], flg_r.carry_flag};
							flg_nxt.carry_flag = i_req.mem[7];
						end
						mrsa_pkg::MRSA_OP_RLFA: begin
							acc_nxt = {i_req.mem[6:0], flg_r.carry_flag};
							flg_nxt.carry_flag = i_req.mem[7];
						end
						mrsa_pkg::MRSA_OP_RRF: begin
							we_nxt = 1'b1;
							wd_nxt = {flg_r.carry_flag, i_req.mem[7:1]};
							flg_nxt.carry_flag = i_req.mem[0];
						end
						mrsa_pkg::MRSA_OP_RRFA: begin
							acc_nxt = {flg_r.carry_flag, i_req.mem[7:1]};
							flg_nxt.carry_flag = i_req.mem[0];
						end
						mrsa_pkg::MRSA_OP_SUBB, mrsa_pkg::MRSA_OP_SUB,
						mrsa_pkg::MRSA_OP_SUBI: begin
							acc_nxt = sub_res;
							flg_nxt = sub_flg;
						end
						mrsa_pkg::MRSA_OP_SUBBM, mrsa_pkg::MRSA_OP_SUBM: begin
							we_nxt  = 1'b1;
							wd_nxt  = sub_res;
							flg_nxt = sub_flg;
						end
						mrsa_pkg::MRSA_OP_DSZ: begin
							we_nxt   = 1'b1;
							wd_nxt   = dec_v;
							skip_nxt = (dec_v == 8'h00);
							st_nxt   = MRSA_ST_DUMMY;
						end
						mrsa_pkg::MRSA_OP_DSZA: begin
							acc_nxt  = dec_v;
							skip_nxt = (dec_v == 8'h00);
							st_nxt   = MRSA_ST_DUMMY;
						end
						mrsa_pkg::MRSA_OP_ISZ: begin
							we_nxt   = 1'b1;
							wd_nxt   = inc_v;
							skip_nxt = (inc_v == 8'h00);
							st_nxt   = MRSA_ST_DUMMY;
						end
						mrsa_pkg::MRSA_OP_ISZA: begin
							acc_nxt  = inc_v;
							skip_nxt = (inc_v == 8'h00);
							st_nxt   = MRSA_ST_DUMMY;
						end
						mrsa_pkg::MRSA_OP_SET: begin
							we_nxt = 1'b1;
							wd_nxt = mrsa_pkg::MRSA_ONES;
						end
						mrsa_pkg::MRSA_OP_SETB: begin
							we_nxt = 1'b1;
							wd_nxt = i_req.mem | (8'h01 << i_req.bit_sel);
						end
						mrsa_pkg::MRSA_OP_SKBS: begin
							skip_nxt = i_req.mem[i_req.bit_sel];
							st_nxt   = MRSA_ST_DUMMY;
						end
						mrsa_pkg::MRSA_OP_SZ: begin
							skip_nxt = (i_req.mem == 8'h00);
							st_nxt   = MRSA_ST_DUMMY;
						end
						mrsa_pkg::MRSA_OP_SZMV: begin
							acc_nxt  = i_req.mem;
							skip_nxt = (i_req.mem == 8'h00);
							st_nxt   = MRSA_ST_DUMMY;
						end
						mrsa_pkg::MRSA_OP_SZB: begin
							skip_nxt = ~i_req.mem[i_req.bit_sel];
							st_nxt   = MRSA_ST_DUMMY;
						end
						mrsa_pkg::MRSA_OP_SWAP: begin
							we_nxt = 1'b1;
							wd_nxt = {i_req.mem[3:0], i_req.mem[7:4]};
						end
						mrsa_pkg::MRSA_OP_SWAPA:
							acc_nxt = {i_req.mem[3:0], i_req.mem[7:4]};
						mrsa_pkg::MRSA_OP_TRDC: begin
							rd_nxt = 1'b1;
							pa_nxt = {i_pc[PC_W-1:8], i_table_pointer};
							st_nxt = MRSA_ST_TABLE;
						end
						mrsa_pkg::MRSA_OP_TRDL: begin
							rd_nxt = 1'b1;
							pa_nxt = {{(PC_W-8){1'b1}}, i_table_pointer};
							st_nxt = MRSA_ST_TABLE;
						end
						mrsa_pkg::MRSA_OP_XOR, mrsa_pkg::MRSA_OP_XORI: begin
							acc_nxt = xres;
							flg_nxt.zero_flag = (xres == 8'h00);
						end
						mrsa_pkg::MRSA_OP_XORMEM: begin
							we_nxt = 1'b1;
							wd_nxt = xres;
							flg_nxt.zero_flag = (xres == 8'h00);
						end
						default: begin
						end
					endcase
				end
			end
			MRSA_ST_DUMMY: begin
				st_nxt = MRSA_ST_IDLE;
			end
			MRSA_ST_TABLE: begin
				we_nxt  = 1'b1;
				wd_nxt  = i_prog_data[7:0];
				tbh_nxt = 8'h00;
				tbh_nxt[WORD_W-9:0] = i_prog_data[WORD_W-1:8];
				st_nxt  = MRSA_ST_IDLE;
			end
			default: st_nxt = MRSA_ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r   <= MRSA_ST_IDLE;
			acc_r  <= mrsa_pkg::MRSA_ACC_RST;
			flg_r  <= mrsa_pkg::MRSA_FLAGS_RST;
			tbh_r  <= mrsa_pkg::MRSA_TBH_RST;
			we_r   <= 1'b0;
			wd_r   <= 8'h00;
			skip_r <= 1'b0;
			rd_r   <= 1'b0;
			pa_r   <= '0;
		end else begin
			st_r   <= st_nxt;
			acc_r  <= acc_nxt;
			flg_r  <= flg_nxt;
			tbh_r  <= tbh_nxt;
			we_r   <= we_nxt;
			wd_r   <= wd_nxt;
			skip_r <= skip_nxt;
			rd_r   <= rd_nxt;
			pa_r   <= pa_nxt;
		end
	end

	assign o_ready            = (st_r == MRSA_ST_IDLE);
	assign o_acc              = acc_r;
	assign o_flags            = flg_r;
	assign o_table_high_latch = tbh_r;
	assign o_mem_we           = we_r;
	assign o_mem_wdata        = wd_r;
	assign o_skip             = skip_r;
	assign o_prog_rd          = rd_r;
	assign o_prog_addr        = pa_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_skip_req;
		i_valid && o_ready && (i_req.op == mrsa_pkg::MRSA_OP_DSZ);
	endsequence

	property p_skip_two;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		s_skip_req |=> !o_ready ##1 o_ready;
	endproperty
	a_skip_two: assert property (p_skip_two)
		else $error("skip op not two cycles");

	property p_dsz_skip;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		s_skip_req |=> (o_skip == (o_mem_wdata == 8'h00)) && o_mem_we;
	endproperty
	a_dsz_skip: assert property (p_dsz_skip)
		else $error("decrement skip wrong");

	property p_rot_left_flag;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_valid && o_ready && i_req.op == mrsa_pkg::MRSA_OP_RLF) |=>
		o_mem_wdata == {$past(i_req.mem[6:0]), $past(o_flags.carry_flag)}
		&& o_flags.carry_flag == $past(i_req.mem[7]);
	endproperty
	a_rot_left_flag: assert property (p_rot_left_flag)
		else $error("left via carry wrong");

	property p_rra_flags;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_valid && o_ready && i_req.op == mrsa_pkg::MRSA_OP_RRA) |=>
		$stable(o_flags) && !o_mem_we;
	endproperty
	a_rra_flags: assert property (p_rra_flags)
		else $error("right rotate touched flags");

	property p_sub_carry;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_valid && o_ready && i_req.op == mrsa_pkg::MRSA_OP_SUB) |=>
		o_flags.carry_flag == ($past(acc_r) >= $past(i_req.mem));
	endproperty
	a_sub_carry: assert property (p_sub_carry)
		else $error("subtract carry wrong");

	property p_swap;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_valid && o_ready && i_req.op == mrsa_pkg::MRSA_OP_SWAPA) |=>
		o_acc == {$past(i_req.mem[3:0]), $past(i_req.mem[7:4])};
	endproperty
	a_swap: assert property (p_swap)
		else $error("swap to accumulator wrong");

	property p_table;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_valid && o_ready && i_req.op == mrsa_pkg::MRSA_OP_TRDL) |=>
		o_prog_rd && o_prog_addr[PC_W-1:8] == '1 ##1 o_mem_we;
	endproperty
	a_table: assert property (p_table)
		else $error("last page table read wrong");

	property p_xor_zero;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_valid && o_ready && i_req.op == mrsa_pkg::MRSA_OP_XOR) |=>
		o_flags.zero_flag == (o_acc == 8'h00) && $stable(o_flags.carry_flag);
	endproperty
	a_xor_zero: assert property (p_xor_zero)
		else $error("xor zero flag wrong");

endmodule

// ==== mrsa_pkg.sv ====
// Package of operation codes, flag layout and reset values for the ALU
package mrsa_pkg;

	// ------------------------------------------------------------
	// Operation codes issued by the decoder
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		MRSA_OP_NONE      = 5'h00,
		MRSA_OP_RLA       = 5'h01,
		MRSA_OP_RR        = 5'h02,
		MRSA_OP_RRA       = 5'h03,
		MRSA_OP_RLF       = 5'h04,
		MRSA_OP_RLFA      = 5'h05,
		MRSA_OP_RRF       = 5'h06,
		MRSA_OP_RRFA      = 5'h07,
		MRSA_OP_SUBB      = 5'h08,
		MRSA_OP_SUBBM     = 5'h09,
		MRSA_OP_SUB       = 5'h0a,
		MRSA_OP_SUBM      = 5'h0b,
		MRSA_OP_SUBI      = 5'h0c,
		MRSA_OP_DSZ       = 5'h0d,
		MRSA_OP_DSZA      = 5'h0e,
		MRSA_OP_ISZ       = 5'h0f,
		MRSA_OP_ISZA      = 5'h10,
		MRSA_OP_SET       = 5'h11,
		MRSA_OP_SETB      = 5'h12,
		MRSA_OP_SKBS      = 5'h13,
		MRSA_OP_SZ        = 5'h14,
		MRSA_OP_SZMV      = 5'h15,
		MRSA_OP_SZB       = 5'h16,
		MRSA_OP_SWAP      = 5'h17,
		MRSA_OP_SWAPA     = 5'h18,
		MRSA_OP_TRDC      = 5'h19,
		MRSA_OP_TRDL      = 5'h1a,
		MRSA_OP_XOR       = 5'h1b,
		MRSA_OP_XORMEM    = 5'h1c,
		MRSA_OP_XORI      = 5'h1d
	} mrsa_op_t;

	// ------------------------------------------------------------
	// Flags and reset values
	// ------------------------------------------------------------
	typedef struct packed {
		logic signed_wrap_flag;
		logic zero_flag;
		logic half_carry_flag;
		logic carry_flag;
	} mrsa_flags_t;

	localparam logic [7:0]  MRSA_ACC_RST   = 8'h00;
	localparam logic [7:0]  MRSA_TBH_RST   = 8'h00;
	localparam logic [3:0]  MRSA_FLAGS_RST = 4'h0;
	localparam logic [7:0]  MRSA_ONES      = 8'hff;
	localparam logic [1:0]  MRSA_SKIP_CYC  = 2'h2;

	// Request from the decoder
	typedef struct packed {
		mrsa_op_t   op;
		logic [7:0] mem;
		logic [7:0] imm;
		logic [2:0] bit_sel;
	} mrsa_req_t;

endpackage

// ==== mrsa_prog_mem.sv ====
// Program memory model that answers the datapath's table reads
`timescale 1ns/100ps
module mrsa_prog_mem #(
	parameter int PC_W   = 11,                     // Program address width
	parameter int WORD_W = 14                      // Program word width
) (
	input  wire logic              i_core_clk,     // Machine-cycle clock
	input  wire logic              i_prog_rd,      // Read strobe
	input  wire logic [PC_W-1:0]   i_prog_addr,    // Read address
	output logic      [WORD_W-1:0] o_prog_data     // Word read back
);
	// ------------------------------------------------------------
	// Word contents and idle pattern
	// ------------------------------------------------------------
	logic [WORD_W-1:0] churn_r = WORD_W'(14'h2a5a); // Idle bus pattern

	// Idle bus changes every cycle so a stale word never looks valid
	always @(negedge i_core_clk) begin
		churn_r <= ~churn_r + WORD_W'(1);
	end

	// Word is the address with a fixed tag and a scrambled low byte
	assign o_prog_data = i_prog_rd ?
		(WORD_W'({3'h5, i_prog_addr}) ^ WORD_W'(14'h00c3)) : churn_r;
endmodule

// ==== tb_mcu_rotate_sub_skip_alu.sv ====
// Self-checking bench for the rotate, subtract and skip datapath
`timescale 1ns/100ps
module tb_mcu_rotate_sub_skip_alu;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                  i_core_clk;      // Machine-cycle clock
	logic                  i_rst_b;         // Reset, active low
	logic                  i_valid;         // Request strobe
	mrsa_pkg::mrsa_req_t   i_req;           // Request to the datapath
	logic [10:0]           i_pc;            // Program counter
	logic [7:0]            i_table_pointer; // Table offset
	logic [13:0]           i_prog_data;     // Word from program memory
	logic                  o_ready;         // Datapath idle
	logic                  o_prog_rd;       // Program read strobe
	logic                  o_mem_we;        // Data memory write
	logic                  o_skip;          // Skip next instruction
	logic [10:0]           o_prog_addr;     // Program read address
	logic [7:0]            o_mem_wdata;     // Data memory byte
	logic [7:0]            o_acc;           // Accumulator
	logic [7:0]            o_table_high_latch; // Table high bits
	mrsa_pkg::mrsa_flags_t o_flags;         // Status flags
	mrsa_pkg::mrsa_flags_t fl_e;            // Expected flags
	logic [7:0]            acc_e;           // Expected accumulator
	int                    n_mismatch = 0;  // Mismatches seen
	int                    cmp_count = 0;   // Comparisons made

	// ------------------------------------------------------------
	// Design and program memory
	// ------------------------------------------------------------
	mrsa_alu dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
		.i_valid(i_valid), .i_req(i_req), .i_pc(i_pc),
		.i_table_pointer(i_table_pointer), .i_prog_data(i_prog_data),
		.o_ready(o_ready), .o_prog_addr(o_prog_addr),
		.o_prog_rd(o_prog_rd), .o_mem_we(o_mem_we),
		.o_mem_wdata(o_mem_wdata), .o_skip(o_skip), .o_acc(o_acc),
		.o_flags(o_flags), .o_table_high_latch(o_table_high_latch));
	mrsa_prog_mem pmem (.i_core_clk(i_core_clk), .i_prog_rd(o_prog_rd),
		.i_prog_addr(o_prog_addr), .o_prog_data(i_prog_data));

	// 40 MHz machine-cycle clock
	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end

	// ------------------------------------------------------------
	// Compare, wait and closing tasks
	// ------------------------------------------------------------
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Drops the strobe while busy and waits, bounded, until a request can be taken
	task automatic wait_ready;
		int n;
		n = 0;
		while (o_ready !== 1'b1) begin
			i_valid = 1'b0;
			@(negedge i_core_clk);
			n++;
			if (n > 8) begin
				n_mismatch++;
				tally_and_finish();
			end
		end
	endtask

	// ------------------------------------------------------------
	// One operation: expected result, then issue and compare
	// ------------------------------------------------------------
	task automatic step(input mrsa_pkg::mrsa_op_t op, input logic [7:0] m,
		input logic [7:0] x = 8'h00, input logic [2:0] bs = 3'h0);
		logic [8:0] d;
		logic [4:0] h;
		logic [7:0] b;
		logic [7:0] r;
		logic       bi, sb, wa, wm, sk, two, zf;
		logic       ci, co;
		{b, r, bi, sb, wa, wm, sk, two, zf} = {m, m, 7'h00};
		ci = fl_e.carry_flag;
		co = ci;
		case (op)
		mrsa_pkg::MRSA_OP_RLA:  {r, wa} = {m[6:0], m[7], 1'b1};
		mrsa_pkg::MRSA_OP_RR:   {r, wm} = {m[0], m[7:1], 1'b1};
		mrsa_pkg::MRSA_OP_RRA:  {r, wa} = {m[0], m[7:1], 1'b1};
		mrsa_pkg::MRSA_OP_RLF:  {r, wm, co} = {m[6:0], ci, 1'b1, m[7]};
		mrsa_pkg::MRSA_OP_RLFA: {r, wa, co} = {m[6:0], ci, 1'b1, m[7]};
		mrsa_pkg::MRSA_OP_RRF:  {r, wm, co} = {ci, m[7:1], 1'b1, m[0]};
		mrsa_pkg::MRSA_OP_RRFA: {r, wa, co} = {ci, m[7:1], 1'b1, m[0]};
		mrsa_pkg::MRSA_OP_SUBB:  {sb, wa, bi} = {2'h3, ~ci};
		mrsa_pkg::MRSA_OP_SUBBM: {sb, wm, bi} = {2'h3, ~ci};
		mrsa_pkg::MRSA_OP_SUB:  {sb, wa} = 2'h3;
		mrsa_pkg::MRSA_OP_SUBM: {sb, wm} = 2'h3;
		mrsa_pkg::MRSA_OP_SUBI: {sb, wa, b} = {2'h3, x};
		mrsa_pkg::MRSA_OP_DSZ:  {r, wm, two} = {m - 8'h01, 2'h3};
		mrsa_pkg::MRSA_OP_DSZA: {r, wa, two} = {m - 8'h01, 2'h3};
		mrsa_pkg::MRSA_OP_ISZ:  {r, wm, two} = {m + 8'h01, 2'h3};
		mrsa_pkg::MRSA_OP_ISZA: {r, wa, two} = {m + 8'h01, 2'h3};
		mrsa_pkg::MRSA_OP_SET:  {r, wm} = {8'hff, 1'b1};
		mrsa_pkg::MRSA_OP_SETB: {r, wm} = {m | (8'h01 << bs), 1'b1};
		mrsa_pkg::MRSA_OP_SKBS: {sk, two} = {m[bs], 1'b1};
		mrsa_pkg::MRSA_OP_SZ:   {sk, two} = {m == 8'h00, 1'b1};
		mrsa_pkg::MRSA_OP_SZMV: {sk, two, wa} = {m == 8'h00, 2'h3};
		mrsa_pkg::MRSA_OP_SZB:  {sk, two} = {~m[bs], 1'b1};
		mrsa_pkg::MRSA_OP_SWAP: {r, wm} = {m[3:0], m[7:4], 1'b1};
		mrsa_pkg::MRSA_OP_SWAPA: {r, wa} = {m[3:0], m[7:4], 1'b1};
		mrsa_pkg::MRSA_OP_XOR:  {r, wa, zf} = {acc_e ^ m, 2'h3};
		mrsa_pkg::MRSA_OP_XORMEM: {r, wm, zf} = {acc_e ^ m, 2'h3};
		mrsa_pkg::MRSA_OP_XORI: {r, wa, zf} = {acc_e ^ x, 2'h3};
		default: ;
		endcase
		// Rotates through the flag hand the carry on
		fl_e.carry_flag = co;
		// Counting skips: the written value differs from the operand
		if (two && r != m)
			sk = (r == 8'h00);
		// Borrow chain: carry set means no borrow out
		if (sb) begin
			d = {1'b0, acc_e} - {1'b0, b} - {8'h00, bi};
			h = {1'b0, acc_e[3:0]} - {1'b0, b[3:0]} - {4'h0, bi};
			r = d[7:0];
			fl_e = {(acc_e[7] ^ b[7]) & (acc_e[7] ^ d[7]),
				d[7:0] == 8'h00, ~h[4], ~d[8]};
		end
		if (zf)
			fl_e.zero_flag = (r == 8'h00);
		if (wa)
			acc_e = r;
		wait_ready();
		i_req = {op, m, x, bs};
		i_valid = 1'b1;
		@(negedge i_core_clk);
		chk_bit(o_ready, ~two);
		chk_bit(o_mem_we, wm);
		if (wm)
			chk_val(16'(o_mem_wdata), 16'(r));
		chk_bit(o_skip, sk);
		chk_val(16'(o_acc), 16'(acc_e));
		chk_val(16'(o_flags), 16'(fl_e));
	endtask

	// Table read: program read at the first cycle, writes at the second
	task automatic tread(input mrsa_pkg::mrsa_op_t op, input logic [10:0] pc,
		input logic [7:0] tp);
		logic [10:0] a;
		logic [13:0] w;
		a = (op == mrsa_pkg::MRSA_OP_TRDL) ? {3'h7, tp} : {pc[10:8], tp};
		w = {3'h5, a} ^ 14'h00c3;
		wait_ready();
		i_pc = pc;
		i_table_pointer = tp;
		i_req = {op, 8'h00, 8'h00, 3'h0};
		i_valid = 1'b1;
		@(negedge i_core_clk);
		i_valid = 1'b0;
		chk_bit(o_prog_rd, 1'b1);
		chk_val(16'(o_prog_addr), 16'(a));
		@(negedge i_core_clk);
		chk_bit(o_mem_we, 1'b1);
		chk_val(16'(o_mem_wdata), 16'(w[7:0]));
		chk_val(16'(o_table_high_latch), 16'(w[13:8]));
		chk_val(16'(o_acc), 16'(acc_e));
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{i_rst_b, i_valid, i_req, i_pc, i_table_pointer} = '0;
		{acc_e, fl_e} = '0;
		repeat (4) @(negedge i_core_clk);
		chk_bit(o_ready, 1'b1);
		chk_val(16'(o_acc), 16'h0000);
		chk_val(16'(o_flags), 16'h0000);
		i_rst_b = 1'b1;
		step(mrsa_pkg::MRSA_OP_XORI, 8'h00, 8'h80);
		step(mrsa_pkg::MRSA_OP_SUBI, 8'h00, 8'h01);
		step(mrsa_pkg::MRSA_OP_SUB, 8'h90);
		step(mrsa_pkg::MRSA_OP_SUBB, 8'h0e);
		step(mrsa_pkg::MRSA_OP_SUBBM, 8'he0);
		step(mrsa_pkg::MRSA_OP_SUBM, 8'hf0);
		step(mrsa_pkg::MRSA_OP_RLF, 8'h81);
		step(mrsa_pkg::MRSA_OP_RLFA, 8'h40);
		step(mrsa_pkg::MRSA_OP_RRF, 8'h01);
		step(mrsa_pkg::MRSA_OP_RRFA, 8'h02);
		step(mrsa_pkg::MRSA_OP_RLA, 8'h81);
		step(mrsa_pkg::MRSA_OP_RR, 8'h01);
		step(mrsa_pkg::MRSA_OP_RRA, 8'h03);
		step(mrsa_pkg::MRSA_OP_DSZ, 8'h01);
		step(mrsa_pkg::MRSA_OP_DSZ, 8'h02);
		step(mrsa_pkg::MRSA_OP_DSZA, 8'h01);
		step(mrsa_pkg::MRSA_OP_ISZ, 8'hff);
		step(mrsa_pkg::MRSA_OP_ISZA, 8'h7f);
		step(mrsa_pkg::MRSA_OP_SET, 8'h5a);
		step(mrsa_pkg::MRSA_OP_SETB, 8'h00, 8'h00, 3'h7);
		step(mrsa_pkg::MRSA_OP_SKBS, 8'h04, 8'h00, 3'h2);
		step(mrsa_pkg::MRSA_OP_SKBS, 8'h04, 8'h00, 3'h3);
		step(mrsa_pkg::MRSA_OP_SZ, 8'h00);
		step(mrsa_pkg::MRSA_OP_SZ, 8'h01);
		step(mrsa_pkg::MRSA_OP_SZMV, 8'h00);
		step(mrsa_pkg::MRSA_OP_SZB, 8'hfe, 8'h00, 3'h0);
		step(mrsa_pkg::MRSA_OP_SWAP, 8'h12);
		step(mrsa_pkg::MRSA_OP_SWAPA, 8'ha5);
		step(mrsa_pkg::MRSA_OP_XOR, 8'h3c);
		step(mrsa_pkg::MRSA_OP_XORI, 8'h00, 8'h66);
		step(mrsa_pkg::MRSA_OP_XORMEM, 8'h96);
		tread(mrsa_pkg::MRSA_OP_TRDC, 11'h5a3, 8'h3c);
		tread(mrsa_pkg::MRSA_OP_TRDL, 11'h123, 8'hc4);
		tally_and_finish();
	end
endmodule
